// ==== src/pin_mode_map.vh ====
// Constants for the per-channel pin driver mode decoder: register offsets, field layouts and reset values.
// Assumes inclusion by bare name from the decoder sources.
`ifndef PIN_MODE_MAP_VH
`define PIN_MODE_MAP_VH

`define ADDR_W              4
`define REG_CTRL0           4'h0
`define REG_CTRL1           4'h1
`define REG_TRIM0           4'h2
`define REG_TRIM1           4'h3
`define REG_STATE0          4'h4
`define REG_STATE1          4'h5

`define CTRL_LOWLEAK        0
`define CTRL_FORCE_EN       1
`define CTRL_FORCE_MODE     2
`define CTRL_MEASURE_MODE   3
`define CTRL_SUPERVOLT      4
`define CTRL_TERM_SEL       5
`define CTRL_LOAD_DIS       6
`define CTRL_RANGE2         7
`define CTRL_W              8
`define CTRL_RESET          8'h04

`define TRIM_SLEW_LSB       0
`define TRIM_DROOP_LSB      2
`define TRIM_RES_LSB        5
`define TRIM_W              9
`define TRIM_RESET          9'h100

`define DRV_LOWLEAK         3'h0
`define DRV_LOW             3'h1
`define DRV_HIGH            3'h2
`define DRV_HIZ             3'h3
`define DRV_TERM            3'h4
`define DRV_SUPER           3'h5

`define PMU_HIZ             3'h0
`define PMU_FORCE_V_MEASURE_I            3'h1
`define PMU_FORCE_V_MEASURE_V            3'h2
`define PMU_FORCE_I_MEASURE_I            3'h3
`define PMU_FORCE_I_MEASURE_V            3'h4
`define PMU_NO_FORCE_NO_MEASURE            3'h5
`define PMU_NO_FORCE_MEASURE_VOLTAGE            3'h6

`endif

// ==== src/channel_mode_decode.v ====
// Combinational mode decode for one channel of the pin driver.
// Assumes registered control bits and already synchronised fast inputs.
`timescale 1ns/100ps
`include "pin_mode_map.vh"

module channel_mode_decode (
  input  wire                 pin_lowleak_en_n,
  input  wire                 pin_supervolt_enable_n,
  input  wire                 receive_ctrl,
  input  wire                 drive_data,
  input  wire [`CTRL_W-1:0]   ctrl,
  output reg  [2:0]           driver_state,
  output reg                  comp_lowleak,
  output reg                  load_lowleak,
  output reg  [2:0]           pmu_state,
  output reg                  range_b_forced,
  output reg                  calibration
);

  reg lowleak;
  reg force_en;
  reg fm;
  reg mm;

  always @* begin
    force_en       = ctrl[`CTRL_FORCE_EN];
    fm             = ctrl[`CTRL_FORCE_MODE];
    mm             = ctrl[`CTRL_MEASURE_MODE];
    lowleak        = ctrl[`CTRL_LOWLEAK] | ~pin_lowleak_en_n; // [RL11]
    calibration    = 1'b0;
    range_b_forced = 1'b0;
    comp_lowleak   = 1'b0;
    load_lowleak   = 1'b0;
    pmu_state      = `PMU_NO_FORCE_NO_MEASURE;
    // Driver level decode, used in normal mode and calibration codes 01 and 11; calibration code 00 overrides it with low-leak.
    if (ctrl[`CTRL_SUPERVOLT] & receive_ctrl) begin
      driver_state = `DRV_SUPER; // [RL10]
    end else if (~ctrl[`CTRL_SUPERVOLT] & ~pin_supervolt_enable_n) begin
      driver_state = `DRV_SUPER; // [RL10]
    end else if (receive_ctrl) begin
      driver_state = ctrl[`CTRL_TERM_SEL] ? `DRV_TERM : `DRV_HIZ; // [RL9]
    end else begin
      driver_state = drive_data ? `DRV_HIGH : `DRV_LOW; // [RL8]
    end
    // Low-leak sits last so the pin overrides every other term; the serial low-leak bit yields to the pin and to force enable.
    if (~pin_lowleak_en_n) begin
      driver_state = `DRV_LOWLEAK; // [RL1] [RL20]
      comp_lowleak = 1'b1;
      load_lowleak = 1'b1;
      pmu_state    = `PMU_HIZ;
    end else if (force_en) begin
      driver_state = `DRV_LOWLEAK; // [RL3]
      comp_lowleak = 1'b1;
      load_lowleak = 1'b1;
      case ({fm, mm})
        2'b00:   pmu_state = `PMU_FORCE_V_MEASURE_I;
        2'b01:   pmu_state = `PMU_FORCE_V_MEASURE_V;
        2'b10:   pmu_state = `PMU_FORCE_I_MEASURE_I;
        default: pmu_state = `PMU_FORCE_I_MEASURE_V;
      endcase
    end else if (lowleak) begin
      driver_state = `DRV_LOWLEAK; // [RL11]
      comp_lowleak = 1'b1;
      load_lowleak = 1'b1;
      pmu_state    = mm ? `PMU_NO_FORCE_MEASURE_VOLTAGE : `PMU_NO_FORCE_NO_MEASURE;
    end else begin
      case ({fm, mm})
        2'b10:   pmu_state = `PMU_NO_FORCE_NO_MEASURE; // [RL4]
        2'b00: begin
          pmu_state    = `PMU_FORCE_V_MEASURE_I; // [RL5]
          driver_state = `DRV_LOWLEAK;
        end
        2'b01:   pmu_state = `PMU_FORCE_I_MEASURE_V; // [RL5]
        default: pmu_state = `PMU_NO_FORCE_MEASURE_VOLTAGE; // [RL5]
      endcase
      calibration    = ({fm, mm} != 2'b10); // [RL6]
      range_b_forced = calibration & ctrl[`CTRL_RANGE2]; // [RL7]
    end
  end

endmodule

// ==== src/pin_driver_mode_decoder.v ====
// Top of the dual-channel pin driver mode decoder with its control registers.
// Assumes a plain register port on sys_clk and fast tester inputs from another domain.
// Operation
// (RL1) Low-leak pin low forces channel low-leak.
// (RL2) Controller holds low-leak pin high otherwise.
// (RL3) Force enable: parametric on, driver low-leak.
// (RL4) Normal operation only with code 10.
// (RL5) Codes 00, 01, 11 select calibration.
// (RL6) Calibration keeps ordinary driver controls. Code 00 here forces the driver low-leak.
// (RL7) Calibration blocks range A, falls to B.
// (RL8) Receive low: data picks high or low.
// (RL9) Receive high: termination select picks level.
// (RL10) Super-voltage by serial bit or pin.
// (RL11) Each channel low-leaks independently.
// (RL12) Controller disables parametric and load first.
// (RL13) Slew field selects 100, 75, 50, 25.
// (RL14) Slew bits reset to zero.
// (RL15) Droop field steps 1.5 percent linearly.
// (RL16) Droop bits reset to zero.
// (RL17) Resistance field trims 360 milliohm steps.
// (RL18) Resistance field resets to 1000.
// (RL19) Reset restores interface and all bits.
// (RL20) Decode combinationally, low-leak takes priority.
// (RL21) Separate fields per channel, shared interface.
`timescale 1ns/100ps
`include "pin_mode_map.vh"

module pin_driver_mode_decoder #(
  parameter CHANNELS = 2
) (
  input  wire                    sys_clk,
  input  wire                    resetn,
  input  wire [`ADDR_W-1:0]      reg_addr,
  input  wire [31:0]             reg_wdata,
  input  wire                    reg_write,
  input  wire                    reg_read,
  output reg  [31:0]             reg_rdata,
  input  wire [CHANNELS-1:0]     pin_lowleak_en_n,
  input  wire [CHANNELS-1:0]     pin_supervolt_enable_n,
  input  wire [CHANNELS-1:0]     receive_ctrl_p,
  input  wire [CHANNELS-1:0]     receive_ctrl_n,
  input  wire [CHANNELS-1:0]     drive_data_p,
  input  wire [CHANNELS-1:0]     drive_data_n,
  output reg  [3*CHANNELS-1:0]   driver_state,
  output reg  [CHANNELS-1:0]     comp_lowleak,
  output reg  [CHANNELS-1:0]     load_lowleak,
  output reg  [CHANNELS-1:0]     load_disable,
  output reg  [3*CHANNELS-1:0]   pmu_state,
  output reg  [CHANNELS-1:0]     range_b_forced,
  output reg  [CHANNELS-1:0]     calibration,
  output reg  [2*CHANNELS-1:0]   slew_sel,
  output reg  [3*CHANNELS-1:0]   droop_comp,
  output reg  [4*CHANNELS-1:0]   out_resistance_trim
);

  // Pins pass two flops; the first stage is read only by the second.
  reg [6*CHANNELS-1:0] pin_meta;
  reg [6*CHANNELS-1:0] pin_sync;

  always @(posedge sys_clk) begin
    if (!resetn) begin
      // Low-leak bits reset asserted, so no channel drives before its real pin level is known. [RL1]
      pin_meta <= {{CHANNELS{1'b0}}, {(5*CHANNELS){1'b1}}};
      pin_sync <= {{CHANNELS{1'b0}}, {(5*CHANNELS){1'b1}}};
    end else begin
      pin_meta <= {pin_lowleak_en_n, pin_supervolt_enable_n, receive_ctrl_p,
                   receive_ctrl_n, drive_data_p, drive_data_n};
      pin_sync <= pin_meta;
    end
  end

  reg [`CTRL_W-1:0] ctrl [0:CHANNELS-1];
  reg [`TRIM_W-1:0] trim [0:CHANNELS-1];
  reg [31:0]        next_rdata;
  wire [3*CHANNELS-1:0] dec_driver;
  wire [CHANNELS-1:0]   dec_comp;
  wire [CHANNELS-1:0]   dec_load;
  wire [3*CHANNELS-1:0] dec_pmu;
  wire [CHANNELS-1:0]   dec_range;
  wire [CHANNELS-1:0]   dec_cal;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gen_ch
      wire sel_ctrl = (reg_addr == `REG_CTRL0 + ch);
      wire sel_trim = (reg_addr == `REG_TRIM0 + ch);
      // Only the positive leg of each differential pair is used; the complement leg is
      // ignored, so the receive/data decision always follows the positive leg.
      wire rcv  = pin_sync[3*CHANNELS+ch];
      wire data = pin_sync[CHANNELS+ch];

      // Reset restores every serial field of both channels. [RL19]
      always @(posedge sys_clk) begin
        if (!resetn) begin
          ctrl[ch] <= `CTRL_RESET;
          trim[ch] <= `TRIM_RESET; // [RL14] [RL16] [RL18]
        end else if (reg_write && sel_ctrl) begin
          ctrl[ch] <= reg_wdata[`CTRL_W-1:0]; // [RL21]
        end else if (reg_write && sel_trim) begin
          trim[ch] <= reg_wdata[`TRIM_W-1:0]; // [RL21]
        end
      end

      channel_mode_decode u_decode (
        .pin_lowleak_en_n       (pin_sync[5*CHANNELS+ch]),
        .pin_supervolt_enable_n (pin_sync[4*CHANNELS+ch]),
        .receive_ctrl           (rcv),
        .drive_data             (data),
        .ctrl                   (ctrl[ch]),
        .driver_state           (dec_driver[3*ch +: 3]),
        .comp_lowleak           (dec_comp[ch]),
        .load_lowleak           (dec_load[ch]),
        .pmu_state              (dec_pmu[3*ch +: 3]),
        .range_b_forced         (dec_range[ch]),
        .calibration            (dec_cal[ch])
      );

      always @(posedge sys_clk) begin
        if (!resetn) begin
          driver_state[3*ch +: 3]        <= `DRV_LOWLEAK;
          comp_lowleak[ch]               <= 1'b1;
          load_lowleak[ch]               <= 1'b1;
          load_disable[ch]               <= 1'b0;
          pmu_state[3*ch +: 3]           <= `PMU_HIZ;
          range_b_forced[ch]             <= 1'b0;
          calibration[ch]                <= 1'b0;
          slew_sel[2*ch +: 2]            <= 2'h0;
          droop_comp[3*ch +: 3]          <= 3'h0;
          out_resistance_trim[4*ch +: 4] <= 4'h8;
        end else begin
          driver_state[3*ch +: 3]        <= dec_driver[3*ch +: 3]; // [RL20]
          comp_lowleak[ch]               <= dec_comp[ch];
          load_lowleak[ch]               <= dec_load[ch];
          load_disable[ch]               <= ctrl[ch][`CTRL_LOAD_DIS];
          pmu_state[3*ch +: 3]           <= dec_pmu[3*ch +: 3];
          range_b_forced[ch]             <= dec_range[ch]; // [RL7]
          calibration[ch]                <= dec_cal[ch];
          slew_sel[2*ch +: 2]            <= trim[ch][`TRIM_SLEW_LSB +: 2]; // [RL13]
          droop_comp[3*ch +: 3]          <= trim[ch][`TRIM_DROOP_LSB +: 3]; // [RL15]
          out_resistance_trim[4*ch +: 4] <= trim[ch][`TRIM_RES_LSB +: 4]; // [RL17]
        end
      end
    end
  endgenerate

  always @* begin
    next_rdata = 32'h0;
    case (reg_addr)
      `REG_CTRL0:  next_rdata[`CTRL_W-1:0] = ctrl[0];
      `REG_CTRL1:  next_rdata[`CTRL_W-1:0] = ctrl[1];
      `REG_TRIM0:  next_rdata[`TRIM_W-1:0] = trim[0];
      `REG_TRIM1:  next_rdata[`TRIM_W-1:0] = trim[1];
      `REG_STATE0: next_rdata[9:0] = {dec_cal[0], dec_range[0], dec_pmu[2:0], dec_load[0], dec_comp[0],
                                     dec_driver[2:0]};
      `REG_STATE1: next_rdata[9:0] = {dec_cal[1], dec_range[1], dec_pmu[5:3], dec_load[1], dec_comp[1],
                                     dec_driver[5:3]};
      default:     next_rdata = 32'h0;
    endcase
  end

  // Read data stands only in the cycle after the strobe, zero otherwise.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_read ? next_rdata : 32'h0;
    end
  end

endmodule

// ==== verif/pin_mode_checker.sv ====
// Concurrent checks on the ports of the pin driver mode decoder.
// Assumes the register map header and the bind at the foot of this file.
`timescale 1ns/100ps
`include "pin_mode_map.vh"
module pin_mode_checker #(
  parameter CHANNELS = 2
) (
  input wire                  sys_clk,
  input wire                  resetn,
  input wire [`ADDR_W-1:0]    reg_addr,
  input wire [31:0]           reg_wdata,
  input wire                  reg_write,
  input wire [CHANNELS-1:0]   pin_lowleak_en_n,
  input wire [CHANNELS-1:0]   pin_supervolt_enable_n,
  input wire [CHANNELS-1:0]   receive_ctrl_p,
  input wire [CHANNELS-1:0]   drive_data_p,
  input wire [3*CHANNELS-1:0] driver_state,
  input wire [CHANNELS-1:0]   comp_lowleak,
  input wire [CHANNELS-1:0]   load_lowleak,
  input wire [3*CHANNELS-1:0] pmu_state,
  input wire [CHANNELS-1:0]   range_b_forced,
  input wire [CHANNELS-1:0]   calibration,
  input wire [2*CHANNELS-1:0] slew_sel,
  input wire [3*CHANNELS-1:0] droop_comp,
  input wire [4*CHANNELS-1:0] out_resistance_trim
);
  // Pins reach the outputs through two sync flops and one output flop, so each pin window is four edges.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire live = pin_lowleak_en_n[0] & pin_supervolt_enable_n[0];
  wire [2:0] drv = driver_state[2:0];
  a_lowleak_pin: assert property (!pin_lowleak_en_n[0] [*4] |=> drv == `DRV_LOWLEAK && pmu_state[2:0] == `PMU_HIZ
    && comp_lowleak[0] && load_lowleak[0]) else $error("low-leak pin not obeyed");
  a_reset_trim: assert property (@(posedge sys_clk) disable iff (1'b0) !resetn |=> slew_sel == 0
    && droop_comp == 0 && out_resistance_trim == 8'h88) else $error("trim fields not at reset value");
  a_data_drive: assert property (($stable(drive_data_p[0]) && live && !receive_ctrl_p[0]) [*4] ##1 drv != 0
    |-> drv == ($past(drive_data_p[0], 2) ? `DRV_HIGH : `DRV_LOW)) else $error("data drive level wrong");
  a_recv_level: assert property ((live && receive_ctrl_p[0]) [*4] ##1 drv != 0
    |-> drv inside {`DRV_HIZ, `DRV_TERM, `DRV_SUPER}) else $error("receive level wrong");
  a_pin_super: assert property ((pin_lowleak_en_n[0] && !pin_supervolt_enable_n[0] && receive_ctrl_p[0]) [*4]
    ##1 drv != 0 |-> drv == `DRV_SUPER) else $error("super-voltage pin not obeyed");
  a_force_dcl: assert property (!calibration[0] && pmu_state[2:0] inside {[`PMU_FORCE_V_MEASURE_I:`PMU_FORCE_I_MEASURE_V]}
    |-> drv == `DRV_LOWLEAK && comp_lowleak[0] && load_lowleak[0]) else $error("forcing without low-leak");
  a_range_cal: assert property (range_b_forced[0] |-> calibration[0]) else $error("range B outside calibration");
  a_cal_pmu: assert property (calibration[0] |-> !(pmu_state[2:0] inside {`PMU_HIZ, `PMU_NO_FORCE_NO_MEASURE}))
    else $error("calibration without active parametric unit");
  a_trim_copy: assert property (reg_write && reg_addr == `REG_TRIM0 ##1 !reg_write [*2] |=>
    {out_resistance_trim[3:0], droop_comp[2:0], slew_sel[1:0]} == $past(reg_wdata[8:0], 3)) else $error("trim copy");
  c_cal: cover property (calibration[0] && range_b_forced[0]);
  c_super: cover property (drv == `DRV_SUPER);
  c_force_i_measure_v: cover property (pmu_state[2:0] == `PMU_FORCE_I_MEASURE_V && !calibration[0]);
endmodule
bind pin_driver_mode_decoder pin_mode_checker #(.CHANNELS(CHANNELS)) i_pin_mode_checker (.*);

// ==== verif/tester_pin_source.sv ====
// Model of the tester timing logic that drives the fast pins of both channels.
// Assumes the bench sets the wanted levels; pins follow a few ns later, unrelated to the clock.
`timescale 1ns/100ps
module tester_pin_source (
  input  wire [7:0] want,
  output reg  [1:0] lowleak_n,
  output reg  [1:0] sv_n,
  output reg  [1:0] rcv_p,
  output reg  [1:0] rcv_n,
  output reg  [1:0] data_p,
  output reg  [1:0] data_n
);
  // The low-leak pin is held high only where the bench permits other modes.
  always @(want) begin
    #3 lowleak_n = want[7:6];
    sv_n = want[5:4];
    {rcv_p, rcv_n} = {want[3:2], ~want[3:2]};
    {data_p, data_n} = {want[1:0], ~want[1:0]};
  end
endmodule

// ==== verif/pin_driver_mode_decoder_tb.sv ====
// Self-checking bench for the pin driver mode decoder.
// Assumes the design, the pin model and the checker are compiled before it.
`timescale 1ns/100ps
`include "pin_mode_map.vh"
module pin_driver_mode_decoder_tb;
  reg         sys_clk = 0, resetn = 0, reg_write = 0, reg_read = 0, rd_q = 0;
  reg  [3:0]  reg_addr = 0;
  reg  [31:0] reg_wdata = 0, r;
  reg  [7:0]  want;
  reg  [3:0]  p;
  reg  [23:0] tbl [0:14];
  reg  [31:0] q [$];
  wire [31:0] reg_rdata;
  wire [1:0]  ll_n, sv_n, rp, rn, dp, dn, comp_ll, load_ll, ld_dis, rng_b, cal;
  wire [3:0]  slew;
  wire [5:0]  droop, drv, parametric_unit;
  wire [7:0]  trim;
  integer     err_total = 0, n_compared = 0, cyc = 0, k;
  initial forever #4 sys_clk = ~sys_clk;
  tester_pin_source i_tester_pin_source (.want(want), .lowleak_n(ll_n), .sv_n(sv_n), .rcv_p(rp), .rcv_n(rn),
    .data_p(dp), .data_n(dn));
  pin_driver_mode_decoder i_pin_driver_mode_decoder (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pin_lowleak_en_n(ll_n), .pin_supervolt_enable_n(sv_n), .receive_ctrl_p(rp), .receive_ctrl_n(rn),
    .drive_data_p(dp), .drive_data_n(dn), .driver_state(drv), .comp_lowleak(comp_ll), .load_lowleak(load_ll),
    .load_disable(ld_dis), .pmu_state(parametric_unit), .range_b_forced(rng_b), .calibration(cal), .slew_sel(slew),
    .droop_comp(droop),
    .out_resistance_trim(trim));
  task cmp(input [31:0] e, input [31:0] s);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("ERROR reg_rdata expected %h seen %h", e, s);
      end
    end
  endtask
  task cmp_out(input [8*8-1:0] what, input [31:0] e, input [31:0] s);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("ERROR %0s expected %h seen %h", what, e, s);
      end
    end
  endtask
  task op(input w, input [3:0] a, input [31:0] d, input [31:0] e);
    begin
      @(posedge sys_clk);
      reg_write <= w;
      reg_read <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      if (!w) q.push_back(e);
      @(posedge sys_clk);
      reg_write <= 0;
      reg_read <= 0;
    end
  endtask
  task end_of_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // Read data stand only in the cycle after the strobe, so the monitor samples mid-cycle.
  always @(negedge sys_clk) begin
    if (rd_q) cmp(q.pop_front(), reg_rdata);
    rd_q <= reg_read;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      end_of_test;
    end
  end
  initial begin
    want <= 8'hF0;
    // Each row: control byte, pins {low-leak, super-voltage, receive, data}, expected state word.
    tbl[0] = 24'h04D0A2; tbl[1] = 24'h04C0A1; tbl[2] = 24'h04E0A3; tbl[3] = 24'h24E0A4;
    // Super-voltage rows switch the load and parametric unit off first.
    tbl[4] = 24'h44A0A5; tbl[5] = 24'h54E0A5;
    tbl[6] = 24'h045018; tbl[7] = 24'h01D0B8; tbl[8] = 24'h02D038; tbl[9] = 24'h0AD058;
    tbl[10] = 24'h0ED098; tbl[11] = 24'h06D078; tbl[12] = 24'h00D220; tbl[13] = 24'h08D282; tbl[14] = 24'h8CD3C2;
    r = $urandom(32'h403d);
    repeat (6) @(posedge sys_clk);
    resetn <= 1;
    op(0, `REG_CTRL0, 0, `CTRL_RESET);
    op(0, `REG_TRIM1, 0, `TRIM_RESET);
    op(1, 4'hF, 32'h1FF, 0);
    op(0, 4'hF, 0, 0);
    for (k = 0; k < 15; k = k + 1) begin
      p = tbl[k][15:12];
      r = $urandom;
      // Control is written before the pins move, so super-voltage never meets an enabled load.
      op(1, `REG_CTRL0 + k[0], tbl[k][23:16], 0);
      want <= k[0] ? {p[3], 1'b0, p[2], 1'b1, p[1], r[0], p[0], r[1]} : {1'b0, p[3], 1'b1, p[2], r[0], p[1], r[1], p[0]};
      repeat (5) @(posedge sys_clk);
      op(0, `REG_STATE0 + k[0], 0, tbl[k][11:0]);
      op(0, `REG_STATE1 - k[0], 0, 32'h018);
      @(negedge sys_clk);
      cmp_out("state", {tbl[k][22], tbl[k][9:0]}, {ld_dis[k[0]], cal[k[0]], rng_b[k[0]], parametric_unit[3*k[0] +: 3],
        load_ll[k[0]], comp_ll[k[0]], drv[3*k[0] +: 3]});
    end
    for (k = 0; k < 6; k = k + 1) begin
      r = $urandom;
      op(1, `REG_TRIM0 + k[0], r, 0);
      op(0, `REG_TRIM0 + k[0], 0, {23'h0, r[8:0]});
      @(negedge sys_clk);
      cmp_out("trim", {23'h0, r[8:0]},
        {trim[4*k[0] +: 4], droop[3*k[0] +: 3], slew[2*k[0] +: 2]});
    end
    @(posedge sys_clk);
    resetn <= 0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1;
    op(0, `REG_TRIM0, 0, `TRIM_RESET);
    op(0, `REG_CTRL1, 0, `CTRL_RESET);
    @(negedge sys_clk);
    cmp_out("trim", {2{`TRIM_RESET}},
      {trim[7:4], droop[5:3], slew[3:2], trim[3:0], droop[2:0], slew[1:0]});
    repeat (3) @(posedge sys_clk);
    end_of_test;
  end
endmodule
